//--- common/wake_timer_pkg.sv
// Package: constants and carrier types for the reset filter and power-up control
package wake_timer_pkg;

    // Clock and time figures
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned XTAL_HZ = 32_768;
    localparam int unsigned SAMPLE_HZ = 8;
    // Crystal edges per 8 Hz sample tick (binary divide by 4096)
    localparam int unsigned XTAL_DIV = XTAL_HZ / SAMPLE_HZ;
    localparam int unsigned XTAL_DIV_W = 12;
    localparam logic [XTAL_DIV_W-1:0] XTAL_DIV_LAST = 12'hfff;
    // Oscillation start signal must drop within this time after release
    localparam int unsigned OSC_DROP_MS = 500;
    // Sample ticks within the drop time: 500 ms at 8 Hz, round down
    localparam int unsigned OSC_DROP_TICKS = OSC_DROP_MS * SAMPLE_HZ / 1000;
    localparam int unsigned SAMPLES = 3;

    // Reset values
    localparam logic FILT_RESET = 1'b0;
    localparam logic OSC_START_RESET = 1'b1;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_READ = 2'b01
    } mode_t;

    // Write transfer status seen from the serial slave
    typedef struct packed {
        logic wake_write;   // Current transfer writes the wake-up register
        logic data_byte;    // Byte is 2nd or later of the transfer
    } wr_req_t;

    typedef struct packed {
        logic osc_start;    // Forces crystal oscillator to run
        logic rst_filt_n;   // Debounced reset, active low
        logic count_run;    // Timer counter may count up
        logic wr_enable;    // Wake-up register writes allowed
    } pwr_status_t;

endpackage

//--- hw/sample_filter.sv
// Module: three-sample majority-free debounce filter on a sample tick
`timescale 1ns/10ps
module sample_filter #(
    parameter int unsigned SAMPLES = wake_timer_pkg::SAMPLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic level_i,
    output logic filt_o
);
    logic [SAMPLES-1:0] hist_r;
    logic [SAMPLES-1:0] hist_nxt;
    logic filt_r;
    logic filt_nxt;

    always_comb begin
        hist_nxt = hist_r;
        filt_nxt = filt_r;
        if (tick_i) begin
            hist_nxt = {hist_r[SAMPLES-2:0], level_i};
        end
        if (&hist_r) begin
            filt_nxt = 1'b1;
        end else if (~|hist_r) begin
            filt_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hist_r <= '0;
            filt_r <= wake_timer_pkg::FILT_RESET;
        end else begin
            hist_r <= hist_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign filt_o = filt_r;
endmodule

//--- hw/reset_powerup_ctrl.sv
// Module: reset pin debounce and power-up control for the wake-up timer
`timescale 1ns/10ps
module reset_powerup_ctrl #(
    parameter int unsigned DIV_W = wake_timer_pkg::XTAL_DIV_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic xtal_i,
    input wire logic rst_pin_n_i,
    input wire wake_timer_pkg::wr_req_t wr_req_i,
    output wake_timer_pkg::pwr_status_t status_o,
    output logic wr_nack_o
);
    // Pin and crystal inputs: three-stage synchronisers
    logic [2:0] pin_sync_r;
    logic [2:0] xtal_sync_r;
    logic xtal_lvl_r;
    logic xtal_lvl_nxt;
    logic xtal_rise;
    logic pin_lvl_r;
    logic pin_lvl_nxt;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_sync_r <= 3'h0;
            xtal_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], rst_pin_n_i};
            xtal_sync_r <= {xtal_sync_r[1:0], xtal_i};
        end
    end

    // A level counts once the second and third stages agree
    always_comb begin
        xtal_lvl_nxt = xtal_lvl_r;
        pin_lvl_nxt = pin_lvl_r;
        if (xtal_sync_r[1] == xtal_sync_r[2]) begin
            xtal_lvl_nxt = xtal_sync_r[2];
        end
        if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_lvl_nxt = pin_sync_r[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xtal_lvl_r <= 1'b0;
            pin_lvl_r <= 1'b0;
        end else begin
            xtal_lvl_r <= xtal_lvl_nxt;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    assign xtal_rise = xtal_lvl_nxt & ~xtal_lvl_r;

    // Crystal divider: no crystal edges, no ticks, so the filter stays low
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    logic tick;

    always_comb begin
        div_nxt = div_r;
        tick = 1'b0;
        // binary divide crystal to 8 Hz
        // Last count is all ones at any DIV_W up to 12, so a narrow divider still ticks
        if (xtal_rise) begin
            div_nxt = div_r + DIV_W'(1);
            tick = (div_r == DIV_W'(wake_timer_pkg::XTAL_DIV_LAST));
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    logic filt_n;

    // short pulses never fill three samples
    sample_filter #(
        .SAMPLES(wake_timer_pkg::SAMPLES)
    ) u_filter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .level_i(pin_lvl_r),
        .filt_o(filt_n)
    );

    // Mode and oscillation start control
    wake_timer_pkg::mode_t mode_r;
    wake_timer_pkg::mode_t mode_nxt;
    logic osc_start_r;
    logic osc_start_nxt;

    always_comb begin
        mode_nxt = mode_r;
        osc_start_nxt = osc_start_r;
        if (!pin_lvl_r) begin
            osc_start_nxt = 1'b1;
        // drop once the filter accepts high
        end else if (filt_n) begin
            osc_start_nxt = 1'b0;
        end
        unique case (mode_r)
            wake_timer_pkg::ST_INIT: begin
                // read mode once reset goes high
                if (filt_n) begin
                    mode_nxt = wake_timer_pkg::ST_READ;
                end
            end
            wake_timer_pkg::ST_READ: begin
                if (!filt_n) begin
                    mode_nxt = wake_timer_pkg::ST_INIT;
                end
            end
            default: mode_nxt = wake_timer_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_r <= wake_timer_pkg::ST_INIT;
            osc_start_r <= wake_timer_pkg::OSC_START_RESET;
        end else begin
            mode_r <= mode_nxt;
            osc_start_r <= osc_start_nxt;
        end
    end

    // filter output is an active-low reset
    // counter held while low, runs while high
    assign status_o.rst_filt_n = filt_n;
    assign status_o.count_run = filt_n;
    assign status_o.osc_start = osc_start_r;
    assign status_o.wr_enable = (mode_r == wake_timer_pkg::ST_READ);
    // refuse data bytes in initial state
    // serial slave state is not touched here
    assign wr_nack_o = wr_req_i.wake_write & wr_req_i.data_byte
        & (mode_r != wake_timer_pkg::ST_READ);

    // Assertions
    sequence s_pin_low;
        !pin_lvl_r;
    endsequence

    a_osc_forced: assert property (@(posedge clk_i)
        disable iff (reset_i)
        s_pin_low |=> status_o.osc_start)
        else $error("oscillator start not forced while pin low");

    a_osc_drop: assert property (@(posedge clk_i)
        disable iff (reset_i)
        (filt_n && pin_lvl_r) |=> !status_o.osc_start)
        else $error("oscillator start did not drop");

    // Filter output lags a tick by two clocks: history, then output
    a_filt_hold: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !tick ##1 !tick |=> $stable(filt_n))
        else $error("filter moved without a sample");

    a_filt_rise: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $rose(filt_n) |-> $past(tick, 2) && $past(pin_lvl_r, 2))
        else $error("filter rose without high samples");

    a_nack_init: assert property (@(posedge clk_i)
        disable iff (reset_i)
        (wr_req_i.wake_write && wr_req_i.data_byte && !filt_n
         && mode_r == wake_timer_pkg::ST_INIT) |-> wr_nack_o)
        else $error("write acknowledged in initial state");

    a_read_mode: assert property (@(posedge clk_i)
        disable iff (reset_i)
        filt_n |=> status_o.wr_enable)
        else $error("read mode not entered");

    // Counter run may only change on a sample that matches its new level
    a_count_run: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $changed(status_o.count_run) |->
        $past(tick, 2) && ($past(pin_lvl_r, 2) == status_o.count_run))
        else $error("counter run changed without matching sample");

    a_start_low: assert property (@(posedge clk_i)
        $fell(reset_i) |-> !filt_n)
        else $error("debounced reset not low after power-on");
endmodule

//--- testbench/host_model.sv
// Host model: drives the reset pin and the write status of the serial slave
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i,
    output logic rst_pin_n_o,
    output wake_timer_pkg::wr_req_t wr_req_o
);
    initial begin
        rst_pin_n_o = 1'b0;
        wr_req_o = '0;
    end

    // level held a whole count of clocks
    task automatic hold_pin(input logic level, input int cycles);
        @(negedge clk_i);
        rst_pin_n_o = level;
        repeat (cycles) @(negedge clk_i);
    endtask

    // write shown as a level, settled before return
    task automatic set_write(input logic wake, input logic data);
        @(negedge clk_i);
        wr_req_o = '{wake_write: wake, data_byte: data};
        #1;
    endtask
endmodule

//--- testbench/testbench.sv
// Testbench: power-up, debounce and write-acknowledge scenarios
`timescale 1ns/10ps
module testbench;
    // System clocks per sample tick: four crystal rises of 620 ns
    localparam int TICK = 25;
    logic clk_i;
    logic reset_i;
    logic xtal_i;
    logic rst_pin_n;
    wake_timer_pkg::wr_req_t wr_req;
    wake_timer_pkg::pwr_status_t st;
    logic nack;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    host_model host_model_i (
        .clk_i(clk_i),
        .rst_pin_n_o(rst_pin_n),
        .wr_req_o(wr_req)
    );
    // Narrow divider keeps the sample tick short
    reset_powerup_ctrl #(.DIV_W(2)) reset_powerup_ctrl_i (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .xtal_i(xtal_i),
        .rst_pin_n_i(rst_pin_n),
        .wr_req_i(wr_req),
        .status_o(st),
        .wr_nack_o(nack)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Crystal phase unrelated to the system clock
    initial begin
        xtal_i = 1'b0;
        forever #310 xtal_i = ~xtal_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wait_filt(input logic v, input int limit);
        int n;
        n = 0;
        while (st.rst_filt_n !== v && n < limit) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    task automatic power_on();
        host_model_i.set_write(1'b1, 1'b1);
        check("osc_start", 1'b1, st.osc_start);
        check("rst_filt_n", 1'b0, st.rst_filt_n);
        check("count_run", 1'b0, st.count_run);
        check("wr_nack data", 1'b1, nack);
        host_model_i.set_write(1'b1, 1'b0);
        check("wr_nack first", 1'b0, nack);
    endtask

    task automatic release_pin();
        host_model_i.hold_pin(1'b1, 2 * TICK - 10);
        check("rst_filt_n early", 1'b0, st.rst_filt_n);
        wait_filt(1'b1, 3 * TICK + 10);
        check("rst_filt_n high", 1'b1, st.rst_filt_n);
        repeat (2) @(negedge clk_i);
        check("count_run", 1'b1, st.count_run);
        check("wr_enable", 1'b1, st.wr_enable);
        check("osc_start", 1'b0, st.osc_start);
        host_model_i.set_write(1'b1, 1'b1);
        check("wr_nack", 1'b0, nack);
    endtask

    // Low pulse of 45 clocks stays under two sample periods
    task automatic glitch();
        host_model_i.hold_pin(1'b0, 10);
        check("osc_start pin low", 1'b1, st.osc_start);
        repeat (34) @(negedge clk_i);
        host_model_i.hold_pin(1'b1, 4 * TICK);
        check("rst_filt_n glitch", 1'b1, st.rst_filt_n);
        check("osc_start after", 1'b0, st.osc_start);
    endtask

    task automatic long_low();
        host_model_i.hold_pin(1'b0, 2 * TICK - 10);
        check("rst_filt_n early", 1'b1, st.rst_filt_n);
        wait_filt(1'b0, 3 * TICK + 10);
        check("rst_filt_n low", 1'b0, st.rst_filt_n);
        repeat (2) @(negedge clk_i);
        check("count_run", 1'b0, st.count_run);
        check("wr_enable", 1'b0, st.wr_enable);
        check("osc_start", 1'b1, st.osc_start);
        check("wr_nack", 1'b1, nack);
    endtask

    initial begin
        reset_i = 1'b1;
        repeat (8) @(negedge clk_i);
        reset_i = 1'b0;
        power_on();
        release_pin();
        glitch();
        long_low();
        wrap_up();
    end
endmodule
